//--- rtl/ttr_bank.sv
`timescale 1ns/1ps
`default_nettype none
module ttr_bank import ttr_pkg::*; (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic reg_wr_en_i,
    input wire logic reg_rd_req_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [31:0] reg_wr_data_i,
    input wire logic [3:0] register_byte_enables_i,
    output logic [31:0] reg_rd_data_o,
    output logic reg_rd_valid_o,
    output logic eng_reg_wr_en_o,
    output logic [7:0] eng_reg_addr_o,
    output logic [31:0] eng_reg_wr_data_o,
    input wire logic [31:0] eng_reg_rd_data_i,
    input wire logic engine_timeout_interrupt_i,
    input wire logic [15:0] rx_fifo_fill_count_i,
    input wire logic tx_fifo_full_i,
    output logic tx_fifo_write_enable_o,
    output logic [31:0] tx_fifo_data_o,
    input wire logic rx_fifo_empty_i,
    output logic rx_fifo_read_enable_o,
    input wire logic [31:0] rx_fifo_data_i
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] tx_len;
        logic verify_en;
        logic soft_rst;
        logic tmo_latch;
        logic [31:0] rd_data;
        logic rd_valid;
    } ttr_bank_state_t;

    ttr_bank_state_t q, d;

    logic eng_hit;
    logic test_hit;
    logic wr_test;
    logic cmd_wr;
    logic rst_wr;
    logic tx_busy;
    logic [31:0] tx_cnt;
    logic rx_fail;
    logic [31:0] rx_cnt;
    logic [31:0] rd_mux;

    assign eng_hit = in_area(reg_addr_i, AREA_ENGINE);
    assign test_hit = in_area(reg_addr_i, AREA_TEST);
    // byte enables are not decoded: every write lands as a full word
    assign wr_test = reg_wr_en_i & test_hit;
    assign cmd_wr = wr_test && (reg_addr_i == ADDR_CMD);
    assign rst_wr = wr_test && (reg_addr_i == ADDR_RST);

    // ----------------------------------------
    // engine forwarding
    // ----------------------------------------
    // passed through unregistered so engine read data meets the read mux
    assign eng_reg_wr_en_o = reg_wr_en_i & eng_hit;
    assign eng_reg_addr_o = reg_addr_i[7:0];
    assign eng_reg_wr_data_o = reg_wr_data_i;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        rd_mux = WORD_ZERO;
        if (eng_hit) begin
            rd_mux = eng_reg_rd_data_i;
        end else if (test_hit) begin
            unique case (reg_addr_i)
                ADDR_TX_LEN: rd_mux = tx_cnt;
                ADDR_CMD: begin
                    rd_mux[CMD_START_BIT] = tx_busy;
                    rd_mux[CMD_VERIFY_BIT] = rx_fail;
                end
                ADDR_RST: begin
                    rd_mux[RST_SOFT_BIT] = q.soft_rst;
                    rd_mux[RST_TMO_BIT] = q.tmo_latch;
                end
                ADDR_FIFO_STAT: begin
                    rd_mux[FILL_W-1:0] = rx_fifo_fill_count_i;
                    rd_mux[FS_FULL_BIT] = tx_fifo_full_i;
                end
                ADDR_RX_LEN: rd_mux = rx_cnt;
                default: rd_mux = WORD_ZERO;
            endcase
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        d = q;
        if (wr_test && reg_addr_i == ADDR_TX_LEN) begin
            d.tx_len = reg_wr_data_i;
        end
        if (cmd_wr) begin
            d.verify_en = reg_wr_data_i[CMD_VERIFY_BIT];
        end
        d.soft_rst = rst_wr & reg_wr_data_i[RST_SOFT_BIT];
        // a timeout seen in the clearing cycle wins over the clear
        d.tmo_latch = engine_timeout_interrupt_i
            | (q.tmo_latch & ~(rst_wr & reg_wr_data_i[RST_TMO_BIT]));
        d.rd_valid = reg_rd_req_i;
        if (reg_rd_req_i) begin
            d.rd_data = rd_mux;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.tx_len <= TX_LEN_RST;
        end else begin
            q <= d;
        end
    end

    assign reg_rd_data_o = q.rd_data;
    assign reg_rd_valid_o = q.rd_valid;

    // ----------------------------------------
    // data path
    // ----------------------------------------
    ttr_tx_gen u_tx_gen (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .clear_i(cmd_wr | q.soft_rst),
        .start_i(cmd_wr & ~reg_wr_data_i[CMD_START_BIT]),
        .total_len_i(q.tx_len),
        .tx_fifo_full_i(tx_fifo_full_i),
        .busy_o(tx_busy),
        .byte_cnt_o(tx_cnt),
        .tx_fifo_write_enable_o(tx_fifo_write_enable_o),
        .tx_fifo_data_o(tx_fifo_data_o)
    );

    ttr_rx_chk u_rx_chk (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .soft_rst_i(q.soft_rst),
        .cnt_clr_i(cmd_wr),
        .verify_en_i(q.verify_en),
        .rx_fifo_empty_i(rx_fifo_empty_i),
        .rx_fifo_data_i(rx_fifo_data_i),
        .rx_fifo_read_enable_o(rx_fifo_read_enable_o),
        .fail_o(rx_fail),
        .byte_cnt_o(rx_cnt)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_rd_valid_delay: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        reg_rd_req_i |=> reg_rd_valid_o && reg_rd_data_o == $past(rd_mux))
        else $error("read answer not one clock after request");
    chk_eng_forward: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (reg_wr_en_i && reg_addr_i[15:8] == AREA_ENGINE) |-> eng_reg_wr_en_o)
        else $error("engine area write not forwarded");
    chk_tx_cnt_clear: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        cmd_wr |=> tx_cnt == WORD_ZERO)
        else $error("transmit count not cleared by command write");
    chk_start_busy: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (cmd_wr && !reg_wr_data_i[CMD_START_BIT]) |=> tx_busy
            ##1 (tx_busy || tx_cnt != 0 || $past(cmd_wr)))
        else $error("start command did not raise busy");
    chk_full_blocks_wr: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        tx_fifo_full_i |-> !tx_fifo_write_enable_o)
        else $error("write while transmit fifo full");
    chk_rd_en_inverse: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        rx_fifo_read_enable_o != rx_fifo_empty_i)
        else $error("read enable does not follow empty");
    chk_soft_rst_pulse: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (rst_wr && reg_wr_data_i[RST_SOFT_BIT] && !$past(rst_wr)) |=> q.soft_rst ##1 !q.soft_rst)
        else $error("soft reset bit did not self-clear");
    chk_tmo_latch_set: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        engine_timeout_interrupt_i |=> q.tmo_latch)
        else $error("timeout not latched");
    chk_tmo_latch_clr: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (rst_wr && reg_wr_data_i[RST_TMO_BIT] && !engine_timeout_interrupt_i) |=> !q.tmo_latch)
        else $error("timeout latch not cleared");
    chk_fifo_status: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (reg_rd_req_i && reg_addr_i == ADDR_FIFO_STAT) |=>
            reg_rd_data_o[FILL_W-1:0] == $past(rx_fifo_fill_count_i)
            && reg_rd_data_o[FS_FULL_BIT] == $past(tx_fifo_full_i))
        else $error("fifo status read wrong");
    chk_hole_zero: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (reg_rd_req_i && reg_addr_i[15:8] == AREA_TEST && reg_addr_i > ADDR_RX_LEN) |=>
            reg_rd_data_o == WORD_ZERO)
        else $error("empty test offset read nonzero");

    // ----------------------------------------
    // register and counter checks
    // ----------------------------------------
    chk_eng_rd_select: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (reg_rd_req_i && eng_hit) |=> reg_rd_data_o == $past(eng_reg_rd_data_i))
        else $error("engine read data not returned");
    chk_eng_wr_pass: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        eng_reg_wr_en_o |->
            eng_reg_addr_o == reg_addr_i[7:0] && eng_reg_wr_data_o == reg_wr_data_i)
        else $error("engine write offset or data altered");
    chk_tx_len_load: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (reg_wr_en_i && reg_addr_i == ADDR_TX_LEN) |=> q.tx_len == $past(reg_wr_data_i))
        else $error("transmit length not loaded as full word");
    chk_tx_len_hold: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        !(reg_wr_en_i && reg_addr_i == ADDR_TX_LEN) |=> $stable(q.tx_len))
        else $error("transmit length changed without its write");
    chk_tx_len_read: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (reg_rd_req_i && reg_addr_i == ADDR_TX_LEN) |=> reg_rd_data_o == $past(tx_cnt))
        else $error("transmit length read not the byte count");
    chk_rx_len_read: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (reg_rd_req_i && reg_addr_i == ADDR_RX_LEN) |=> reg_rd_data_o == $past(rx_cnt))
        else $error("receive length read not the byte count");
    chk_cmd_busy_read: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (reg_rd_req_i && reg_addr_i == ADDR_CMD) |=>
            reg_rd_data_o[CMD_START_BIT] == $past(tx_busy))
        else $error("command read busy bit wrong");
    chk_cmd_fail_read: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (reg_rd_req_i && reg_addr_i == ADDR_CMD) |=>
            reg_rd_data_o[CMD_VERIFY_BIT] == $past(rx_fail))
        else $error("command read fail bit wrong");
    chk_tmo_read: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (reg_rd_req_i && reg_addr_i == ADDR_RST) |=>
            reg_rd_data_o[RST_TMO_BIT] == $past(q.tmo_latch))
        else $error("reset register read timeout bit wrong");
    chk_tmo_latch_hold: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (q.tmo_latch && !(rst_wr && reg_wr_data_i[RST_TMO_BIT])) |=> q.tmo_latch)
        else $error("timeout latch dropped without a clear");
    chk_verify_load: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        cmd_wr |=> q.verify_en == $past(reg_wr_data_i[CMD_VERIFY_BIT]))
        else $error("verification select not loaded");
    chk_verify_hold: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        !cmd_wr |=> $stable(q.verify_en))
        else $error("verification select changed without command");
    chk_soft_clr_tx: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (q.soft_rst && !cmd_wr) |=> !tx_busy && tx_cnt == WORD_ZERO)
        else $error("soft reset left generator running");
    chk_soft_clr_rx: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        q.soft_rst |=> rx_cnt <= BYTES_PER_WORD)
        else $error("soft reset left receive count");
    chk_idle_cmd: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (cmd_wr && reg_wr_data_i[CMD_START_BIT]) |=> !tx_busy)
        else $error("command with bit0 set started transmit");
    chk_idle_no_wr: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        !tx_busy |-> !tx_fifo_write_enable_o)
        else $error("fifo write while generator idle");
    chk_no_restart: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (!tx_busy && !cmd_wr) |=> !tx_busy)
        else $error("generator restarted without command");
    chk_tx_cnt_step: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (tx_fifo_write_enable_o && !cmd_wr && !q.soft_rst) |=>
            tx_cnt == $past(tx_cnt) + BYTES_PER_WORD)
        else $error("byte count did not step with a write");
    chk_tx_cnt_hold: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (!tx_fifo_write_enable_o && !cmd_wr && !q.soft_rst) |=> $stable(tx_cnt))
        else $error("byte count moved without a write");
    chk_rd_idle: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        !reg_rd_req_i |=> !reg_rd_valid_o && $stable(reg_rd_data_o))
        else $error("read answer without request");
    chk_other_area_zero: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (reg_rd_req_i && !eng_hit && !test_hit) |=> reg_rd_data_o == WORD_ZERO)
        else $error("unmapped offset read nonzero");
endmodule
`default_nettype wire

//--- rtl/ttr_pkg.sv
// Operation
// - engine area 0x0000-0x00FF forwarded to engine
// - engine registers at fixed word offsets
// - transmit length reads byte count, cleared on command
// - command write with bit0 zero starts transmit
// - command bit1 write selects receive verification
// - command bit0 reads transmit busy
// - command bit1 reads verification fail
// - reset bit0 resets test logic, self-clearing
// - reset bit8 write clears timeout latch
// - reset bit8 reads latched engine timeout
// - fifo status low half is receive fill
// - fifo status bit24 is transmit full
// - receive length reads byte count, cleared on command
// - read data and valid one clock later
// - byte enables ignored, full-word writes only
// - incrementing pattern, write held off while full
// - read enable inverts empty, data checked
`default_nettype none
package ttr_pkg;
    // ----------------------------------------
    // address map
    // ----------------------------------------
    localparam logic [15:0] ADDR_TX_LEN = 16'h1000;
    localparam logic [15:0] ADDR_CMD = 16'h1004;
    localparam logic [15:0] ADDR_RST = 16'h1008;
    localparam logic [15:0] ADDR_FIFO_STAT = 16'h100C;
    localparam logic [15:0] ADDR_RX_LEN = 16'h1010;
    localparam logic [7:0] AREA_ENGINE = 8'h00;
    localparam logic [7:0] AREA_TEST = 8'h10;
    localparam logic [7:0] ENG_OFS_RESET = 8'h00;
    localparam logic [7:0] ENG_OFS_CMD = 8'h04;
    localparam logic [7:0] ENG_OFS_PKT_LEN = 8'h28;
    localparam logic [7:0] ENG_OFS_SERVER_MODE = 8'h38;
    // ----------------------------------------
    // fields and reset values
    // ----------------------------------------
    localparam int CMD_START_BIT = 0;
    localparam int CMD_VERIFY_BIT = 1;
    localparam int RST_SOFT_BIT = 0;
    localparam int RST_TMO_BIT = 8;
    localparam int FS_FULL_BIT = 24;
    localparam int FILL_W = 16;
    localparam logic [31:0] BYTES_PER_WORD = 32'h0000_0004;
    localparam logic [31:0] TX_LEN_RST = 32'h0000_0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    function automatic logic in_area(input logic [15:0] addr, input logic [7:0] area);
        in_area = (addr[15:8] == area);
    endfunction
endpackage
`default_nettype wire

//--- rtl/ttr_rx_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ttr_rx_chk import ttr_pkg::*; (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic soft_rst_i,
    input wire logic cnt_clr_i,
    input wire logic verify_en_i,
    input wire logic rx_fifo_empty_i,
    input wire logic [31:0] rx_fifo_data_i,
    output logic rx_fifo_read_enable_o,
    output logic fail_o,
    output logic [31:0] byte_cnt_o
);
    typedef struct packed {
        logic en1;
        logic en2;
        logic [31:0] data;
        logic [31:0] exp_word;
        logic fail;
        logic [31:0] cnt;
    } ttr_rx_state_t;

    ttr_rx_state_t q, d;
    logic mismatch;

    always_comb begin
        d = q;
        d.en1 = ~rx_fifo_empty_i;
        d.en2 = q.en1;
        if (q.en1) begin
            d.data = rx_fifo_data_i;
        end
        mismatch = q.en2 && verify_en_i && (q.data != q.exp_word);
        if (soft_rst_i) begin
            d.exp_word = WORD_ZERO;
            d.fail = 1'b0;
        end else if (q.en2) begin
            d.exp_word = q.exp_word + 32'h0000_0001;
        end
        // a mismatch in the clearing cycle is kept
        if (mismatch) begin
            d.fail = 1'b1;
        end
        if (soft_rst_i || cnt_clr_i) begin
            d.cnt = WORD_ZERO;
        end
        if (q.en2) begin
            d.cnt = d.cnt + BYTES_PER_WORD;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rx_fifo_read_enable_o = ~rx_fifo_empty_i;
    assign fail_o = q.fail;
    assign byte_cnt_o = q.cnt;

    chk_rx_fail_set: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (q.en2 && verify_en_i && q.data != q.exp_word) |=> fail_o)
        else $error("mismatch did not raise fail");
    chk_rx_no_verify: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!verify_en_i && !fail_o) |=> !fail_o)
        else $error("fail raised with verification off");
    chk_rx_cnt_clear: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        cnt_clr_i |=> byte_cnt_o <= BYTES_PER_WORD)
        else $error("receive count not cleared");
endmodule
`default_nettype wire

//--- rtl/ttr_tx_gen.sv
`timescale 1ns/1ps
`default_nettype none
module ttr_tx_gen import ttr_pkg::*; (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic start_i,
    input wire logic [31:0] total_len_i,
    input wire logic tx_fifo_full_i,
    output logic busy_o,
    output logic [31:0] byte_cnt_o,
    output logic tx_fifo_write_enable_o,
    output logic [31:0] tx_fifo_data_o
);
    typedef struct packed {
        logic busy;
        logic [31:0] cnt;
    } ttr_tx_state_t;

    ttr_tx_state_t q, d;
    logic wr;
    logic [32:0] next_cnt;

    always_comb begin
        d = q;
        wr = q.busy & ~tx_fifo_full_i;
        next_cnt = {1'b0, q.cnt} + {1'b0, BYTES_PER_WORD};
        if (clear_i) begin
            d.busy = start_i;
            d.cnt = WORD_ZERO;
        end else if (wr) begin
            d.cnt = next_cnt[31:0];
            // 33-bit compare: a length near the top must not wrap the count
            if (next_cnt >= {1'b0, total_len_i}) begin
                d.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign busy_o = q.busy;
    assign byte_cnt_o = q.cnt;
    assign tx_fifo_write_enable_o = wr;
    assign tx_fifo_data_o = {2'b00, q.cnt[31:2]};

    chk_tx_stop_at_len: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!clear_i && wr && next_cnt >= {1'b0, total_len_i}) |=> !busy_o)
        else $error("generator kept running past programmed length");
    chk_tx_pattern_step: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!clear_i && wr) |=> tx_fifo_data_o == $past(tx_fifo_data_o) + 32'h0000_0001)
        else $error("pattern did not increment after a write");
endmodule
`default_nettype wire

//--- verification/ttr_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ttr_bank_tb import ttr_pkg::*; ;
    logic core_clk, rst_b, wr_en, rd_req, tx_stall, rx_go, rx_bad, tmo;
    logic [15:0] addr, fill;
    logic [31:0] wdata, rdata, eng_rd, eng_wd, tx_data, tx_words, rx_data, d;
    logic [3:0] be;
    logic rd_valid, eng_we, full, tx_we, empty, rx_re, tx_bad;
    logic [7:0] eng_addr;
    int mismatches, n_tests, i;
    ttr_bank DUT (.core_clk_i(core_clk), .rst_b_i(rst_b), .reg_wr_en_i(wr_en),
        .reg_rd_req_i(rd_req), .reg_addr_i(addr), .reg_wr_data_i(wdata),
        .register_byte_enables_i(be), .reg_rd_data_o(rdata), .reg_rd_valid_o(rd_valid),
        .eng_reg_wr_en_o(eng_we), .eng_reg_addr_o(eng_addr), .eng_reg_wr_data_o(eng_wd),
        .eng_reg_rd_data_i(eng_rd), .engine_timeout_interrupt_i(tmo),
        .rx_fifo_fill_count_i(fill), .tx_fifo_full_i(full), .tx_fifo_write_enable_o(tx_we),
        .tx_fifo_data_o(tx_data), .rx_fifo_empty_i(empty), .rx_fifo_read_enable_o(rx_re),
        .rx_fifo_data_i(rx_data));
    ttr_engine_model u_eng (.core_clk_i(core_clk), .rst_b_i(rst_b), .eng_reg_wr_en_i(eng_we),
        .eng_reg_addr_i(eng_addr), .eng_reg_wr_data_i(eng_wd), .eng_reg_rd_data_o(eng_rd),
        .tx_stall_i(tx_stall), .tx_fifo_full_o(full), .tx_fifo_write_enable_i(tx_we),
        .tx_fifo_data_i(tx_data), .tx_words_o(tx_words), .tx_bad_o(tx_bad), .rx_go_i(rx_go),
        .rx_bad_i(rx_bad), .rx_fifo_empty_o(empty), .rx_fifo_read_enable_i(rx_re),
        .rx_fifo_data_o(rx_data));
    // ----------------------------------------
    // clock and access tasks
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge core_clk);
        #1;
        wr_en = 1'b1;
        addr = a;
        wdata = v;
        @(posedge core_clk);
        #1;
        wr_en = 1'b0;
    endtask
    // address held until the edge after valid rises
    task automatic rd(input logic [15:0] a, output logic [31:0] v);
        @(posedge core_clk);
        #1;
        rd_req = 1'b1;
        addr = a;
        @(posedge core_clk);
        #1;
        rd_req = 1'b0;
        chk({31'h0, rd_valid}, 32'h1);
        v = rdata;
        @(posedge core_clk);
        #1;
        chk({31'h0, rd_valid}, 32'h0);
    endtask
    task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    task automatic rx_send(input int n, input logic bad);
        @(posedge core_clk);
        #1;
        rx_bad = bad;
        rx_go = 1'b1;
        repeat (n) @(posedge core_clk);
        #1;
        rx_go = 1'b0;
        rx_bad = 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    task automatic run_tests();
        {rst_b, wr_en, rd_req, tx_stall, rx_go, rx_bad, tmo} = 7'h00;
        addr = 16'h0000;
        wdata = 32'h0;
        be = 4'hF;
        fill = 16'hA5C3;
        mismatches = 0;
        n_tests = 0;
        repeat (3) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        repeat (3) @(posedge core_clk);
        rdc(ADDR_TX_LEN, 32'h0);
        rdc(ADDR_CMD, 32'h0);
        rdc(ADDR_RX_LEN, 32'h0);
        $display("test reset_values done");
        wr(16'h0028, 32'hA5A5_0028);
        wr(16'h0038, 32'h5A5A_0038);
        wr(16'h0000, 32'h0000_1111);
        // only byte 1 enabled: honouring enables would leave the length at zero
        be = 4'h2;
        wr(ADDR_TX_LEN, 32'h0000_0040);
        be = 4'hF;
        rdc(16'h0028, 32'hA5A5_0028);
        rdc(16'h0038, 32'h5A5A_0038);
        rdc(16'h0000, 32'h0000_1111);
        $display("test engine_forward done");
        wr(16'h1020, 32'hFFFF_FFFF);
        wr(ADDR_RX_LEN, 32'h0000_1234);
        rdc(16'h1020, 32'h0);
        rdc(16'h0400, 32'h0);
        rdc(ADDR_RX_LEN, 32'h0);
        tx_stall = 1'b1;
        rdc(ADDR_FIFO_STAT, 32'h0100_A5C3);
        tx_stall = 1'b0;
        rdc(ADDR_FIFO_STAT, 32'h0000_A5C3);
        $display("test holes_status done");
        wr(ADDR_CMD, 32'h0);
        tx_stall = 1'b1;
        rdc(ADDR_CMD, 32'h1);
        d = tx_words;
        repeat (4) @(posedge core_clk);
        #1;
        chk(tx_words, d);
        tx_stall = 1'b0;
        for (i = 0; i < 40; i++) begin
            rd(ADDR_CMD, d);
            if (d[0] === 1'b0) break;
        end
        if (i == 40) begin
            mismatches++;
            return;
        end
        chk(tx_words, 32'h10);
        chk({31'h0, tx_bad}, 32'h0);
        rdc(ADDR_TX_LEN, 32'h0000_0040);
        wr(ADDR_CMD, 32'h1);
        rdc(ADDR_TX_LEN, 32'h0);
        rdc(ADDR_CMD, 32'h0);
        chk(tx_words, 32'h10);
        $display("test transmit done");
        wr(ADDR_RST, 32'h1);
        rdc(ADDR_RST, 32'h0);
        wr(ADDR_CMD, 32'h3);
        rx_send(8, 1'b0);
        rdc(ADDR_RX_LEN, 32'h20);
        rdc(ADDR_CMD, 32'h0);
        rx_send(1, 1'b1);
        rdc(ADDR_RX_LEN, 32'h24);
        rdc(ADDR_CMD, 32'h2);
        wr(ADDR_CMD, 32'h3);
        rdc(ADDR_RX_LEN, 32'h0);
        rdc(ADDR_CMD, 32'h2);
        wr(ADDR_RST, 32'h1);
        rdc(ADDR_CMD, 32'h0);
        // checker restarts at zero, model does not: mismatches unless ignored
        wr(ADDR_CMD, 32'h1);
        rx_send(2, 1'b0);
        rdc(ADDR_CMD, 32'h0);
        rdc(ADDR_RX_LEN, 32'h8);
        $display("test receive done");
        @(posedge core_clk);
        #1;
        tmo = 1'b1;
        @(posedge core_clk);
        #1;
        tmo = 1'b0;
        rdc(ADDR_RST, 32'h100);
        rdc(ADDR_RST, 32'h100);
        wr(ADDR_RST, 32'h100);
        rdc(ADDR_RST, 32'h0);
        $display("test timeout_latch done");
    endtask
    initial begin
        run_tests();
        complete_run();
    end
endmodule
`default_nettype wire

//--- verification/ttr_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module ttr_engine_model (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic eng_reg_wr_en_i,
    input wire logic [7:0] eng_reg_addr_i,
    input wire logic [31:0] eng_reg_wr_data_i,
    output logic [31:0] eng_reg_rd_data_o,
    input wire logic tx_stall_i,
    output logic tx_fifo_full_o,
    input wire logic tx_fifo_write_enable_i,
    input wire logic [31:0] tx_fifo_data_i,
    output logic [31:0] tx_words_o,
    output logic tx_bad_o,
    input wire logic rx_go_i,
    input wire logic rx_bad_i,
    output logic rx_fifo_empty_o,
    input wire logic rx_fifo_read_enable_i,
    output logic [31:0] rx_fifo_data_o
);
    logic [31:0] regs [0:63];
    logic [31:0] rx_seq;
    // engine read is combinational, same cycle as the address
    assign eng_reg_rd_data_o = regs[eng_reg_addr_i[7:2]];
    assign tx_fifo_full_o = tx_stall_i;
    assign rx_fifo_empty_o = ~rx_go_i;
    always_ff @(posedge core_clk_i) begin
        if (eng_reg_wr_en_i) begin
            regs[eng_reg_addr_i[7:2]] <= eng_reg_wr_data_i;
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_words_o <= 32'h0;
            tx_bad_o <= 1'b0;
            rx_seq <= 32'h0;
            rx_fifo_data_o <= 32'h0;
        end else begin
            if (tx_fifo_write_enable_i) begin
                if (tx_fifo_full_o || (tx_fifo_data_i !== tx_words_o)) begin
                    tx_bad_o <= 1'b1;
                end
                tx_words_o <= tx_words_o + 32'h1;
            end
            // data follows the read enable by one clock, toggles when not read
            if (rx_fifo_read_enable_i) begin
                rx_fifo_data_o <= rx_bad_i ? ~rx_seq : rx_seq;
                rx_seq <= rx_seq + 32'h1;
            end else begin
                rx_fifo_data_o <= ~rx_fifo_data_o;
            end
        end
    end
endmodule
`default_nettype wire
